// File: dv/fdd_drive_model.sv
/*
 Behavioural model of one flexible disk drive on the shared cable.
 Assumes the host drives the pin struct and the bench drives the protect tab.
*/
`timescale 1ns/100ps
module fdd_drive_model #(
	parameter int unsigned JUMPER = 1
)(
	input  wire fdd_host_pkg::drive_pins_t pins,
	input  wire logic                      prot,
	output logic                           media_locked_n,
	output logic [7:0]                     track,
	output logic                           side1,
	output logic                           motor,
	output logic [15:0]                    flips
);
	import fdd_host_pkg::*;
	logic picked;
	assign picked = (pins.unit_pick_n[JUMPER] === 1'b0);
	assign media_locked_n = picked ? !prot : 1'b1;
	assign motor = !pins.spindle_run_n;
	initial
	begin
		track = 8'h00;
		flips = 16'h0000;
		side1 = 1'b0;
	end
	always @*
		if (picked)
			side1 = !pins.surface_choice_n;
	always @(negedge pins.step_n)
		if (picked)
			track <= pins.direction_n ? track - 8'h01 : track + 8'h01;
	always @(negedge pins.record_stream_n)
		if (picked && !pins.record_permit_n && !prot)
			flips <= flips + 16'h0001;
endmodule

// File: dv/fdd_host_port_tb_top.sv
/*
 Self-checking bench for the host disk port with one drive model on unit one.
 Assumes shortened timing parameters and a single 100 MHz clock.
*/
`timescale 1ns/100ps
module fdd_host_port_tb_top;
	import fdd_host_pkg::*;
	localparam int unsigned SPIN = 200;
	logic        clk;
	logic        rst_n;
	logic        cmd_valid;
	cmd_t        cmd;
	logic        cmd_ready;
	logic        cmd_refused;
	logic        flux_valid;
	logic        flux_ready;
	logic        spin_on;
	logic        spin_ready;
	logic        rw_ok;
	logic        media_locked_n;
	logic        prot;
	drive_pins_t pins;
	logic [7:0]  track;
	logic        side1;
	logic        motor;
	logic [15:0] flips;
	logic        r;
	int          err_count;
	int          n_compared;
	int          cycles;
	fdd_host_port #(.STEP_PERIOD(300), .SEEK_SETTLE(500), .SPIN_UP(SPIN), .ERASE_TAIL(50)) i_dut (
		.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.cmd_refused(cmd_refused), .flux_valid(flux_valid), .flux_ready(flux_ready), .spin_on(spin_on),
		.spin_ready(spin_ready), .rw_ok(rw_ok), .media_locked_n(media_locked_n), .pins(pins));
	fdd_drive_model #(.JUMPER(1)) i_drive (
		.pins(pins), .prot(prot), .media_locked_n(media_locked_n), .track(track), .side1(side1),
		.motor(motor), .flips(flips));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard well above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			err_count++;
			summarize();
		end
	end
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000)
			chk_bit(cmd_ready, 1'b1);
	endtask
	// Flag serves as both inward and side1; refusal is caught over three edges
	task automatic send(input op_t op, input logic [1:0] unit, input logic [7:0] steps, input logic flag);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, unit: unit, inward: flag, side1: flag, steps: steps};
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		r = 1'b0;
		repeat (3)
		begin
			@(posedge clk);
			r |= (cmd_refused === 1'b1);
		end
	endtask
	task automatic flux(input int n);
		repeat (n)
		begin
			@(posedge clk);
			flux_valid <= 1'b1;
			do @(posedge clk); while (flux_ready !== 1'b1);
			flux_valid <= 1'b0;
		end
	endtask
	task automatic t_reset();
		chk_val({6'h00, pins}, 16'h03ff);
		chk_bit(media_locked_n, 1'b1);
		$display("t_reset done");
	endtask
	task automatic t_seek();
		send(OP_SELECT, 2'd1, 8'h00, 1'b0);
		chk_val({12'h000, pins.unit_pick_n}, 16'h000d);
		send(OP_SEEK, 2'd1, 8'h03, 1'b1);
		chk_bit(pins.direction_n, 1'b0);
		wait_ready();
		chk_val({8'h00, track}, 16'h0003);
		send(OP_SEEK, 2'd1, 8'h01, 1'b0);
		wait_ready();
		chk_val({8'h00, track}, 16'h0002);
		send(OP_SELECT, 2'd2, 8'h00, 1'b0);
		send(OP_SEEK, 2'd2, 8'h02, 1'b1);
		wait_ready();
		chk_val({8'h00, track}, 16'h0002);
		send(OP_SELECT, 2'd1, 8'h00, 1'b0);
		$display("t_seek done");
	endtask
	task automatic t_side();
		send(OP_SIDE, 2'd1, 8'h00, 1'b1);
		wait_ready();
		chk_bit(pins.surface_choice_n, 1'b0);
		chk_bit(side1, 1'b1);
		send(OP_SIDE, 2'd1, 8'h00, 1'b0);
		wait_ready();
		chk_bit(side1, 1'b0);
		$display("t_side done");
	endtask
	task automatic t_write();
		int k;
		send(OP_WRITE_BEGIN, 2'd1, 8'h00, 1'b0);
		chk_bit(r, 1'b1);
		@(posedge clk);
		spin_on <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (spin_ready !== 1'b1 && k < 1000);
		chk_bit(motor, 1'b1);
		chk_bit(k >= SPIN - 1 && k <= SPIN + 4, 1'b1);
		chk_bit(rw_ok, 1'b1);
		send(OP_SEEK, 2'd1, 8'h01, 1'b1);
		chk_bit(rw_ok, 1'b0);
		wait_ready();
		chk_bit(rw_ok, 1'b1);
		chk_val({8'h00, track}, 16'h0003);
		send(OP_WRITE_BEGIN, 2'd1, 8'h00, 1'b0);
		chk_bit(r, 1'b0);
		chk_bit(pins.record_permit_n, 1'b0);
		flux(5);
		send(OP_WRITE_END, 2'd1, 8'h00, 1'b0);
		chk_bit(pins.record_permit_n, 1'b1);
		wait_ready();
		chk_val(flips, 16'h0005);
		prot <= 1'b1;
		send(OP_WRITE_BEGIN, 2'd1, 8'h00, 1'b0);
		chk_bit(r, 1'b1);
		prot <= 1'b0;
		send(OP_SELECT, 2'd2, 8'h00, 1'b0);
		send(OP_WRITE_BEGIN, 2'd2, 8'h00, 1'b0);
		flux(2);
		send(OP_WRITE_END, 2'd2, 8'h00, 1'b0);
		wait_ready();
		chk_val(flips, 16'h0005);
		@(posedge clk);
		spin_on <= 1'b0;
		repeat (3) @(posedge clk);
		chk_bit(motor, 1'b0);
		chk_bit(spin_ready, 1'b0);
		chk_bit(rw_ok, 1'b0);
		$display("t_write done");
	endtask
	initial
	begin
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		flux_valid = 1'b0;
		spin_on = 1'b0;
		prot = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_seek();
		t_side();
		t_write();
		summarize();
	end
endmodule

// File: hw/fdd_host_pkg.sv
/*
 Shared types and timing constants for the host-side flexible disk port.
 Assumes a 100 MHz system clock and a drive cable where every line is active low.
 // Function
 // [RULE1] All cable lines active low
 // [RULE2] Drive answers only while picked
 // [RULE3] Drive's pick line set by jumper
 // [RULE4] Direction low inward, high outward
 // [RULE5] Direction changes only before step pulses
 // [RULE6] One step pulse moves one track
 // [RULE7] Wait seek plus settle after stepping
 // [RULE8] Side line low picks side one
 // [RULE9] Wait after side change before access
 // [RULE10] Side held until erase tail ends
 // [RULE11] Write permit low records, high reads
 // [RULE12] Permit ignored when protected or unpicked
 // [RULE13] Each falling stream edge flips current
 // [RULE14] Stream accepted only when permitted
 // [RULE15] Spindle line runs motor, unselected
 // [RULE16] Spindle at speed within half second
 // [RULE17] Unpicked drive holds outputs high
*/
package fdd_host_pkg;

	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned DIR_SETUP_NS   = 1000;
	localparam int unsigned STEP_LOW_NS    = 1000;
	localparam int unsigned FLUX_LOW_NS    = 250;
	localparam int unsigned SIDE_SETTLE_NS = 20000;
	localparam int unsigned SEEK_MS        = 6;
	localparam int unsigned HEAD_SETTLE_MS = 15;
	localparam int unsigned SPIN_UP_MS     = 500;
	localparam int unsigned ERASE_TAIL_US  = 1000;
	localparam int unsigned NS_PER_MS      = 1000000;
	localparam int unsigned NS_PER_US      = 1000;

	// Least times round up
	localparam int unsigned DIR_SETUP_CYC   = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STEP_LOW_CYC    = (STEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FLUX_LOW_CYC    = (FLUX_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SIDE_SETTLE_CYC = (SIDE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STEP_PERIOD_CYC = SEEK_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned SEEK_SETTLE_CYC = (SEEK_MS + HEAD_SETTLE_MS) * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned SPIN_UP_CYC     = SPIN_UP_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned ERASE_TAIL_CYC  = ERASE_TAIL_US * NS_PER_US / CLK_PERIOD_NS;

	localparam int unsigned UNITS     = 4;
	localparam logic [3:0]  PICK_NONE = 4'hf;
	localparam logic [3:0]  PICK_ONE  = 4'h1;
	localparam logic [31:0] TIMER_ZERO = 32'h0;

	typedef enum logic [2:0] {
		OP_SELECT,
		OP_DESELECT,
		OP_SEEK,
		OP_SIDE,
		OP_WRITE_BEGIN,
		OP_WRITE_END
	} op_t;

	typedef struct packed {
		op_t        op;
		logic [1:0] unit;
		logic       inward;
		logic       side1;
		logic [7:0] steps;
	} cmd_t;

	typedef struct packed {
		logic [3:0] unit_pick_n;
		logic       direction_n;
		logic       step_n;
		logic       surface_choice_n;
		logic       record_permit_n;
		logic       record_stream_n;
		logic       spindle_run_n;
	} drive_pins_t;

endpackage

// File: hw/fdd_host_port.sv
/*
 Host controller that drives one shared flexible disk cable: unit pick, stepping,
 side choice, gated write stream and spindle run. Commands arrive on a valid/ready
 port; flux requests arrive one per transition. Assumes all inputs are synchronous
 to clk and that the drive itself applies its own pick gating.
*/
`timescale 1ns/100ps
module fdd_host_port #(
	parameter int unsigned STEP_PERIOD = fdd_host_pkg::STEP_PERIOD_CYC,
	parameter int unsigned SEEK_SETTLE = fdd_host_pkg::SEEK_SETTLE_CYC,
	parameter int unsigned SPIN_UP     = fdd_host_pkg::SPIN_UP_CYC,
	parameter int unsigned ERASE_TAIL  = fdd_host_pkg::ERASE_TAIL_CYC
)(
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      cmd_valid,
	input  wire fdd_host_pkg::cmd_t        cmd,
	output logic                           cmd_ready,
	output logic                           cmd_refused,
	input  wire logic                      flux_valid,
	output logic                           flux_ready,
	input  wire logic                      spin_on,
	output logic                           spin_ready,
	output logic                           rw_ok,
	input  wire logic                      media_locked_n,
	output fdd_host_pkg::drive_pins_t      pins
);
	import fdd_host_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE,
		S_DIR_SETUP,
		S_STEP_LOW,
		S_STEP_GAP,
		S_SETTLE,
		S_SIDE_WAIT,
		S_WRITING,
		S_ERASE
	} state_t;

	logic        rst_meta;
	logic        rst_q;
	state_t      state;
	state_t      next_state;
	logic [31:0] timer;
	logic [31:0] next_timer;
	logic [7:0]  steps_left;
	logic [7:0]  next_steps_left;
	logic [31:0] flux_timer;
	logic [31:0] next_flux_timer;
	drive_pins_t next_pins;
	logic        next_cmd_ready;
	logic        next_cmd_refused;
	logic        next_flux_ready;
	logic        next_rw_ok;
	logic [31:0] spin_timer;
	logic [31:0] next_spin_timer;
	logic        next_spin_ready;
	logic        picked;
	logic        take;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'b0;
			rst_q    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_q    <= rst_meta;
		end
	end

	// [RULE2] pick any drive
	assign picked = (pins.unit_pick_n != PICK_NONE);
	assign take   = cmd_valid && cmd_ready;

	always_comb
	begin
		next_state       = state;
		next_pins        = pins;
		next_steps_left  = steps_left;
		next_timer       = (timer == TIMER_ZERO) ? TIMER_ZERO : timer - 32'h1;
		next_flux_timer  = (flux_timer == TIMER_ZERO) ? TIMER_ZERO : flux_timer - 32'h1;
		next_cmd_refused = 1'b0;
		// [RULE15] spindle run level
		next_pins.spindle_run_n = !spin_on;
		unique case (state)
			S_IDLE:
			begin
				if (take)
				begin
					unique case (cmd.op)
						OP_SELECT:
						begin
							// [RULE3] one line per unit
							next_pins.unit_pick_n = ~(PICK_ONE << cmd.unit);
						end
						OP_DESELECT:
						begin
							next_pins.unit_pick_n = PICK_NONE;
						end
						OP_SEEK:
						begin
							if (cmd.steps != 8'h0)
							begin
								// [RULE4] [RULE5] direction before steps
								next_pins.direction_n = !cmd.inward;
								next_steps_left       = cmd.steps;
								next_timer            = 32'(DIR_SETUP_CYC - 1);
								next_state            = S_DIR_SETUP;
							end
						end
						OP_SIDE:
						begin
							// [RULE8] low picks side one
							next_pins.surface_choice_n = !cmd.side1;
							next_timer                 = 32'(SIDE_SETTLE_CYC - 1);
							next_state                 = S_SIDE_WAIT;
						end
						OP_WRITE_BEGIN:
						begin
							// [RULE12] never permit when protected
							if (media_locked_n && picked && spin_ready)
							begin
								// [RULE11] permit low records
								next_pins.record_permit_n = 1'b0;
								next_state                = S_WRITING;
							end
							else
							begin
								next_cmd_refused = 1'b1;
							end
						end
						default:
						begin
							next_cmd_refused = 1'b1;
						end
					endcase
				end
			end
			S_DIR_SETUP, S_STEP_GAP:
			begin
				if (timer == TIMER_ZERO)
				begin
					next_pins.step_n = 1'b0;
					next_timer       = 32'(STEP_LOW_CYC - 1);
					next_state       = S_STEP_LOW;
				end
			end
			S_STEP_LOW:
			begin
				if (timer == TIMER_ZERO)
				begin
					// [RULE6] one pulse per track
					next_pins.step_n = 1'b1;
					next_steps_left  = steps_left - 8'h1;
					if (steps_left == 8'h1)
					begin
						// [RULE7] seek plus settle wait
						next_timer = 32'(SEEK_SETTLE - 1);
						next_state = S_SETTLE;
					end
					else
					begin
						next_timer = 32'(STEP_PERIOD - STEP_LOW_CYC - 1);
						next_state = S_STEP_GAP;
					end
				end
			end
			S_SETTLE, S_SIDE_WAIT:
			begin
				// [RULE9] settle before access
				if (timer == TIMER_ZERO)
					next_state = S_IDLE;
			end
			S_WRITING:
			begin
				if (flux_valid && flux_ready)
				begin
					// [RULE13] one low pulse per flux
					next_pins.record_stream_n = 1'b0;
					next_flux_timer           = 32'(FLUX_LOW_CYC - 1);
				end
				else if (flux_timer == TIMER_ZERO)
					next_pins.record_stream_n = 1'b1;
				if (take && cmd.op != OP_WRITE_END)
					next_cmd_refused = 1'b1;
				if (!media_locked_n || (take && cmd.op == OP_WRITE_END))
				begin
					// [RULE14] stream only while permitted
					next_pins.record_permit_n = 1'b1;
					next_pins.record_stream_n = 1'b1;
					next_flux_timer           = TIMER_ZERO;
					next_timer                = 32'(ERASE_TAIL - 1);
					next_state                = S_ERASE;
				end
			end
			S_ERASE:
			begin
				// [RULE10] side held through erase tail
				if (timer == TIMER_ZERO)
					next_state = S_IDLE;
			end
		endcase
		next_cmd_ready  = (next_state == S_IDLE) || (next_state == S_WRITING);
		next_flux_ready = (next_state == S_WRITING) && next_pins.record_stream_n && (next_flux_timer == TIMER_ZERO);
		next_rw_ok      = (next_state == S_IDLE) && next_spin_ready && (next_pins.unit_pick_n != PICK_NONE);
	end

	always_ff @(posedge clk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			state       <= S_IDLE;
			timer       <= TIMER_ZERO;
			flux_timer  <= TIMER_ZERO;
			steps_left  <= 8'h0;
			// [RULE1] all lines idle high
			pins        <= '1;
			cmd_ready   <= 1'b0;
			cmd_refused <= 1'b0;
			flux_ready  <= 1'b0;
			rw_ok       <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			timer       <= next_timer;
			flux_timer  <= next_flux_timer;
			steps_left  <= next_steps_left;
			pins        <= next_pins;
			cmd_ready   <= next_cmd_ready;
			cmd_refused <= next_cmd_refused;
			flux_ready  <= next_flux_ready;
			rw_ok       <= next_rw_ok;
		end
	end

	// Spin-up counter restarts whenever the motor is told to stop
	always_comb
	begin
		next_spin_timer = spin_timer;
		next_spin_ready = spin_ready;
		if (!spin_on)
		begin
			next_spin_timer = 32'(SPIN_UP - 1);
			next_spin_ready = 1'b0;
		end
		// [RULE16] ready after spin-up time
		else if (spin_timer == TIMER_ZERO)
			next_spin_ready = 1'b1;
		else
			next_spin_timer = spin_timer - 32'h1;
	end

	always_ff @(posedge clk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			spin_timer <= 32'(SPIN_UP - 1);
			spin_ready <= 1'b0;
		end
		else
		begin
			spin_timer <= next_spin_timer;
			spin_ready <= next_spin_ready;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_q);

	single_pick_a: assert property ($onehot0(~pins.unit_pick_n)) // [RULE2]
		else $error("more than one drive picked");
	dir_stable_a: assert property (!pins.step_n |-> $stable(pins.direction_n)) // [RULE5]
		else $error("direction moved during step");
	step_width_a: assert property ($fell(pins.step_n) |-> (!pins.step_n)[*8]) // [RULE6]
		else $error("step pulse too short");
	protect_drop_a: assert property (!media_locked_n |=> pins.record_permit_n) // [RULE12]
		else $error("permit held on protected media");
	stream_gate_a: assert property (!pins.record_stream_n |-> !pins.record_permit_n) // [RULE14]
		else $error("stream pulse without permit");
	side_hold_a: assert property (!pins.record_permit_n |=> $stable(pins.surface_choice_n)) // [RULE10]
		else $error("side changed while writing");
	spin_wait_a: assert property ($fell(pins.spindle_run_n) |-> (!spin_ready)[*8]) // [RULE16]
		else $error("spin ready too early");
	settle_gap_a: assert property ($rose(pins.step_n) |-> !rw_ok[*8]) // [RULE7]
		else $error("access allowed before settle");
	permit_pick_a: assert property (!pins.record_permit_n |-> pins.unit_pick_n != PICK_NONE) // [RULE11]
		else $error("permit with no drive picked");

	seek_done_c: cover property ($rose(pins.step_n) ##[1:1000] (state == S_IDLE));
	write_flux_c: cover property (!pins.record_permit_n ##1 $fell(pins.record_stream_n));
	spin_up_c: cover property ($rose(spin_ready));
	refuse_c: cover property (cmd_refused);
endmodule
